//--- hdl/scs_clock_switch.sv
// clock mode register and glitch free system clock selection
`timescale 1ns/1ps
`default_nettype none
`include "scs_defines.svh"
// Functional notes
// - Software may rewrite clock mode any time; new clock follows that write.
// - Mode 0x34 selects fast divided by two, slow oscillator kept on.
// - Mode 0xF4 selects slow with fast on; fast turned off later.
// - Slow oscillator may be cleared later; clearing its bit stops it.
// - Mode 0x14 from fast divided by two selects fast divided by four.
// - Bit 4 enables fast oscillator, bit 2 slow, independently.
// - After reset both oscillators are enabled.
module scs_clock_switch (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic modeWrEn,
	input wire logic [7:0] modeWrData,
	output logic [7:0] clkModeQ,
	output logic fastOscEn,
	output logic slowOscEn,
	output logic sysClkTick,
	output logic sysClkSlow,
	output logic switchBusy
);
	scs_pkg::scs_regs_t r_q, r_d;
	logic [1:0] oscEn;
	logic [1:0] oscTick;
	logic srcTick;
	logic divDone;
	scs_pkg::scs_sel_t wantSel;

	function automatic scs_pkg::scs_sel_t decodeSel(input logic [7:0] m);
		logic [3:0] code;
		code = {m[`SCS_SEL_HI:`SCS_SEL_LO], m[`SCS_SEL_B0]};
		case (code)
			`SCS_CODE_DIV2: decodeSel = scs_pkg::SEL_DIV2;
			`SCS_CODE_DIV4: decodeSel = scs_pkg::SEL_DIV4;
			`SCS_CODE_DIV8: decodeSel = scs_pkg::SEL_DIV8;
			`SCS_CODE_DIV16: decodeSel = scs_pkg::SEL_DIV16;
			`SCS_CODE_DIV32: decodeSel = scs_pkg::SEL_DIV32;
			default: decodeSel = scs_pkg::SEL_SLOW;
		endcase
	endfunction

	function automatic logic [4:0] divLimit(input scs_pkg::scs_sel_t s);
		case (s)
			scs_pkg::SEL_DIV2: divLimit = `SCS_LIM_DIV2;
			scs_pkg::SEL_DIV4: divLimit = `SCS_LIM_DIV4;
			scs_pkg::SEL_DIV8: divLimit = `SCS_LIM_DIV8;
			scs_pkg::SEL_DIV16: divLimit = `SCS_LIM_DIV16;
			scs_pkg::SEL_DIV32: divLimit = `SCS_LIM_DIV32;
			default: divLimit = '0;
		endcase
	endfunction

	// index 0 is the fast oscillator, index 1 the slow one
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : gOsc
			scs_osc_if oscBus ();
			scs_osc_tick #(
				.PERIOD(gi == 0 ? `SCS_FAST_PERIOD : `SCS_SLOW_PERIOD)
			) uOsc (
				.clk(sys_clk),
				.rst(rst),
				.bus(oscBus.osc)
			);
			assign oscBus.en = oscEn[gi];
			assign oscTick[gi] = oscBus.tick;
		end
	endgenerate

	// each enable bit drives only its own oscillator
	assign oscEn[0] = r_q.mode[`SCS_FAST_EN_BIT];
	assign oscEn[1] = r_q.mode[`SCS_SLOW_EN_BIT];

	assign wantSel = decodeSel(r_q.mode);
	assign srcTick = (r_q.sel == scs_pkg::SEL_SLOW) ? oscTick[1] : oscTick[0];
	assign divDone = srcTick && (r_q.pre == divLimit(r_q.sel));

	always_comb begin
		r_d = r_q;
		r_d.tick = 1'b0;
		if (modeWrEn) begin
			r_d.mode = modeWrData;
		end
		case (r_q.st)
			scs_pkg::ST_RUN, scs_pkg::ST_DRAIN: begin
				if (srcTick) begin
					r_d.pre = divDone ? '0 : r_q.pre + `SCS_PRE_ONE;
				end
				r_d.tick = divDone;
				if (r_q.st == scs_pkg::ST_RUN && wantSel != r_q.sel) begin
					// finish the running period of the old source first
					r_d.st = scs_pkg::ST_DRAIN;
				end else if (r_q.st == scs_pkg::ST_DRAIN && divDone) begin
					r_d.sel = wantSel;
					r_d.pre = '0;
					r_d.st = scs_pkg::ST_SYNC;
				end
			end
			scs_pkg::ST_SYNC: begin
				// drop the partial first period of the new source
				if (srcTick) begin
					r_d.st = scs_pkg::ST_RUN;
				end
			end
			default: r_d.st = scs_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			r_q.mode <= `SCS_MODE_RESET;
			r_q.sel <= scs_pkg::SEL_SLOW;
			r_q.st <= scs_pkg::ST_RUN;
			r_q.pre <= '0;
			r_q.tick <= 1'b0;
		end else begin
			r_q <= r_d;
		end
	end

	// a source stopped by software simply stops the system clock
	assign clkModeQ = r_q.mode;
	assign fastOscEn = r_q.mode[`SCS_FAST_EN_BIT];
	assign slowOscEn = r_q.mode[`SCS_SLOW_EN_BIT];
	assign sysClkTick = r_q.tick;
	assign sysClkSlow = (r_q.sel == scs_pkg::SEL_SLOW);
	assign switchBusy = (r_q.st != scs_pkg::ST_RUN);

	a_write_stores_mode: assert property (@(posedge sys_clk) disable iff (rst)
		modeWrEn |=> clkModeQ == $past(modeWrData)) else $error("mode write not stored");

	a_boot_both_on: assert property (@(posedge sys_clk)
		rst |=> (fastOscEn && slowOscEn && sysClkSlow)) else $error("oscillators off after reset");

	a_enable_bits_map: assert property (@(posedge sys_clk) disable iff (rst)
		modeWrEn |=> (fastOscEn == $past(modeWrData[`SCS_FAST_EN_BIT]))
			&& (slowOscEn == $past(modeWrData[`SCS_SLOW_EN_BIT])))
		else $error("enable bits do not follow mode bits 4 and 2");

	a_slow_stop: assert property (@(posedge sys_clk) disable iff (rst)
		(modeWrEn && !modeWrData[`SCS_SLOW_EN_BIT]) |=> ##1 !oscTick[1][*3])
		else $error("slow oscillator still running after its bit cleared");

	a_div2_select: assert property (@(posedge sys_clk) disable iff (rst)
		(modeWrEn && modeWrData == `SCS_MODE_FAST_DIV2 && !switchBusy
			&& oscEn[0] && oscEn[1] && !(r_q.sel == scs_pkg::SEL_DIV2))
		##1 !modeWrEn[*8] |-> ##[0:72] (r_q.sel == scs_pkg::SEL_DIV2) && slowOscEn)
		else $error("0x34 did not select fast divided by two");

	a_slow_select: assert property (@(posedge sys_clk) disable iff (rst)
		(modeWrEn && modeWrData == `SCS_MODE_SLOW_KEEP && !switchBusy && oscEn[0])
		##1 !modeWrEn[*8] |-> ##[1:120] sysClkSlow && fastOscEn)
		else $error("0xF4 did not reach slow source with fast kept on");

	a_div4_select: assert property (@(posedge sys_clk) disable iff (rst)
		(modeWrEn && modeWrData == `SCS_MODE_FAST_DIV4 && !switchBusy
			&& r_q.sel == scs_pkg::SEL_DIV2)
		##1 !modeWrEn[*8] |-> ##[0:4] r_q.sel == scs_pkg::SEL_DIV4 && slowOscEn)
		else $error("0x14 did not move divided by two to divided by four");

	a_no_runt_tick: assert property (@(posedge sys_clk) disable iff (rst)
		sysClkTick |=> !sysClkTick[*3]) else $error("system clock period shorter than four cycles");

	a_source_on_switch: assert property (@(posedge sys_clk) disable iff (rst)
		$changed(r_q.sel) |-> sysClkTick && switchBusy)
		else $error("source changed outside a period boundary");
endmodule
`default_nettype wire

//--- hdl/scs_defines.svh
// constants of the system clock switch
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

`define SCS_MODE_RESET 8'hF4
`define SCS_FAST_EN_BIT 4
`define SCS_SLOW_EN_BIT 2
`define SCS_SEL_HI 7
`define SCS_SEL_LO 5
`define SCS_SEL_B0 3

`define SCS_CODE_DIV2 4'h2
`define SCS_CODE_DIV4 4'h0
`define SCS_CODE_DIV8 4'h3
`define SCS_CODE_DIV16 4'h1
`define SCS_CODE_DIV32 4'h7
`define SCS_CODE_SLOW 4'hE

`define SCS_LIM_DIV2 5'h01
`define SCS_LIM_DIV4 5'h03
`define SCS_LIM_DIV8 5'h07
`define SCS_LIM_DIV16 5'h0F
`define SCS_LIM_DIV32 5'h1F
`define SCS_PRE_ONE 5'h01

`define SCS_FAST_PERIOD 2
`define SCS_SLOW_PERIOD 32
`define SCS_OSC_CNT_W 6
`define SCS_OSC_CNT_ONE 6'h01

`define SCS_MODE_FAST_DIV2 8'h34
`define SCS_MODE_FAST_DIV4 8'h14
`define SCS_MODE_SLOW_KEEP 8'hF4

`endif

//--- hdl/scs_osc_if.sv
// enable and tick between the switch and one oscillator model
`timescale 1ns/1ps
`default_nettype none
interface scs_osc_if;
	logic en;
	logic tick;
	modport ctrl (output en, input tick);
	modport osc (input en, output tick);
endinterface
`default_nettype wire

//--- hdl/scs_osc_tick.sv
// one rc oscillator seen as a periodic enable pulse
`timescale 1ns/1ps
`default_nettype none
`include "scs_defines.svh"
module scs_osc_tick #(
	parameter int PERIOD = `SCS_FAST_PERIOD
) (
	input wire logic clk,
	input wire logic rst,
	scs_osc_if.osc bus
);
	localparam logic [5:0] LAST = 6'(PERIOD - 1);
	scs_pkg::scs_osc_regs_t r_q, r_d;

	always_comb begin
		r_d = r_q;
		r_d.tick = 1'b0;
		if (!bus.en) begin
			// stopped oscillator: no edges, phase restarts
			r_d.cnt = '0;
		end else if (r_q.cnt == LAST) begin
			r_d.cnt = '0;
			r_d.tick = 1'b1;
		end else begin
			r_d.cnt = r_q.cnt + `SCS_OSC_CNT_ONE;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign bus.tick = r_q.tick;

	a_osc_stops: assert property (@(posedge clk) disable iff (rst)
		!bus.en |=> !bus.tick) else $error("oscillator ticked while disabled");
endmodule
`default_nettype wire

//--- hdl/scs_pkg.sv
// types of the system clock switch
package scs_pkg;
	typedef enum logic [2:0] {SEL_DIV2, SEL_DIV4, SEL_DIV8, SEL_DIV16, SEL_DIV32, SEL_SLOW} scs_sel_t;
	typedef enum logic [1:0] {ST_RUN, ST_DRAIN, ST_SYNC} scs_state_t;
	typedef struct packed {
		logic [7:0] mode;
		scs_sel_t sel;
		scs_state_t st;
		logic [4:0] pre;
		logic tick;
	} scs_regs_t;
	typedef struct packed {
		logic [5:0] cnt;
		logic tick;
	} scs_osc_regs_t;
endpackage

//--- tb/scs_clock_switch_tb.sv
// self-checking bench of the system clock switch
`timescale 1ns/1ps
`default_nettype none
module scs_clock_switch_tb;
	logic sys_clk, rst, modeWrEn;
	logic [7:0] modeWrData, clkModeQ;
	logic fastOscEn, slowOscEn, sysClkTick, sysClkSlow, switchBusy;
	int err_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int lastTick = -100;
	logic [7:0] modeTab [7] = '{8'h34, 8'h14, 8'h3C, 8'h1C, 8'h7C, 8'hF4, 8'hE4};
	scs_clock_switch dut (.sys_clk(sys_clk), .rst(rst), .modeWrEn(modeWrEn),
		.modeWrData(modeWrData), .clkModeQ(clkModeQ), .fastOscEn(fastOscEn),
		.slowOscEn(slowOscEn), .sysClkTick(sysClkTick), .sysClkSlow(sysClkSlow),
		.switchBusy(switchBusy));
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// model: system clock gap in sys_clk cycles for a mode value
	function automatic int expGap(input logic [7:0] v);
		case ({v[7:5], v[3]})
			4'b0010: return 4;
			4'b0000: return 8;
			4'b0011: return 16;
			4'b0001: return 32;
			4'b0111: return 64;
			default: return 32;
		endcase
	endfunction
	// no two system clock ticks closer than the fastest period
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (sysClkTick === 1'b1) begin
			chk(8'(cyc - lastTick >= 4), 8'h01);
			lastTick <= cyc;
		end
	end
	task automatic settle();
		int n;
		n = 0;
		repeat (3) @(posedge sys_clk);
		while (switchBusy !== 1'b0 && n < 400) begin
			@(posedge sys_clk);
			n++;
		end
		chk(8'(n < 400), 8'h01);
	endtask
	task automatic measureChk(input logic [7:0] v);
		int n;
		int t0;
		n = 0;
		do @(posedge sys_clk); while (sysClkTick !== 1'b1 && ++n < 200);
		t0 = cyc;
		do @(posedge sys_clk); while (sysClkTick !== 1'b1 && ++n < 400);
		chk(8'(cyc - t0), 8'(expGap(v)));
		chk(8'(sysClkSlow), 8'(expGap(v) == 32 && {v[7:5], v[3]} != 4'b0001));
	endtask
	task automatic apply(input logic [7:0] v);
		modeWrEn <= 1'b1;
		modeWrData <= v;
		@(posedge sys_clk);
		modeWrEn <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk(clkModeQ, v);
		chk(8'(fastOscEn), 8'(v[4]));
		chk(8'(slowOscEn), 8'(v[2]));
		settle();
		measureChk(v);
		$display("test mode %h done", v);
	endtask
	task automatic resetChk();
		rst <= 1'b1;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk(clkModeQ, 8'hF4);
		chk({6'h00, fastOscEn, slowOscEn}, 8'h03);
		chk(8'(sysClkSlow), 8'h01);
		$display("test reset done");
	endtask
	initial begin
		rst = 1'b1;
		modeWrEn = 1'b0;
		modeWrData = 8'h00;
		void'($urandom(82));
		resetChk();
		@(posedge sys_clk);
		for (int i = 0; i < 7; i++)
			apply({modeTab[i][7:2], 2'($urandom_range(3))});
		apply(8'hF4);
		apply(8'h34);
		apply(8'h30);
		apply(8'h34);
		modeWrEn <= 1'b1;
		modeWrData <= 8'h14;
		@(posedge sys_clk);
		modeWrData <= 8'h34;
		@(posedge sys_clk);
		modeWrEn <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk(clkModeQ, 8'h34);
		settle();
		measureChk(8'h34);
		$display("test back to back done");
		@(posedge sys_clk);
		resetChk();
		report_and_stop();
	end
	initial begin
		#(25 * 40000);
		err_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
